// *** hdl/pwa_ctl.sv ***
// local controller: AXI4-Lite slave that forwards register accesses
// to the window bank and gates the initialization-complete flag
// assumes the bank answers each req with ack one cycle later
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pwa_ctl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    pwa_if.ctl               rp,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             init_complete
);
    // ==========================================================
    // state
    pwa_pkg::pwa_state_e state;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [31:0] wdat_reg;
    logic [31:0] rdat_reg;
    logic        mask_done;
    logic        offs_done;
    logic        bad_mask;
    logic        wr_fire;
    logic        cmd_go;
    logic        dev_wr;
    logic [31:0] status;
    logic [9:0]  fld;
    logic        legal;

    // strobes are ignored: every register is one whole word
    assign wr_fire = !awready && !wready && !bvalid;
    assign cmd_go  = wr_fire && aw_addr == pwa_pkg::CTL_CMD && state == pwa_pkg::ST_IDLE;
    assign dev_wr  = w_data[pwa_pkg::CMD_WE_BIT];
    assign status  = {28'h0, offs_done, mask_done, bad_mask, state == pwa_pkg::ST_WAIT};
    assign fld     = wdat_reg[pwa_pkg::FLD_HI:pwa_pkg::FLD_LO];

    // legal masks are low-contiguous ones in the field, nothing else, or NO_WINDOW for the sdram mask
    always_comb begin
        legal = ((fld & (fld + 10'h001)) == 10'h000)
             && ((wdat_reg & ~pwa_pkg::FLD_BITS) == pwa_pkg::ZERO32); // [RULE8] [RULE13]
        if (rp.addr == pwa_pkg::OFS_SDRAM_MASK && wdat_reg == pwa_pkg::NO_WINDOW) begin
            legal = 1'b1; // [RULE12]
        end
    end

    // ==========================================================
    // AXI4-Lite write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= pwa_pkg::RESP_OKAY;
            aw_addr <= 8'h00;
            w_data  <= pwa_pkg::ZERO32;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= (aw_addr > pwa_pkg::CTL_CONTROL || aw_addr[1:0] != 2'h0)
                          ? pwa_pkg::RESP_SLVERR : pwa_pkg::RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= pwa_pkg::ZERO32;
            rresp   <= pwa_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= pwa_pkg::RESP_OKAY;
            case (araddr)
                pwa_pkg::CTL_WDATA:   rdata <= wdat_reg;
                pwa_pkg::CTL_RDATA:   rdata <= rdat_reg;
                pwa_pkg::CTL_STATUS:  rdata <= status;
                pwa_pkg::CTL_CONTROL: rdata <= {30'h0, init_complete, 1'b0};
                pwa_pkg::CTL_CMD:     rdata <= {23'h0, rp.addr};
                default: begin
                    rdata <= pwa_pkg::ZERO32;
                    rresp <= pwa_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // command sequencer toward the bank; commands while busy are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= pwa_pkg::ST_IDLE;
            rp.req   <= 1'b0;
            rp.we    <= 1'b0;
            rp.addr  <= 9'h000;
            rp.wdata <= pwa_pkg::ZERO32;
            wdat_reg <= pwa_pkg::ZERO32;
            rdat_reg <= pwa_pkg::ZERO32;
        end else begin
            rp.req <= 1'b0;
            if (wr_fire && aw_addr == pwa_pkg::CTL_WDATA) begin
                wdat_reg <= w_data;
            end
            case (state)
                pwa_pkg::ST_IDLE: begin
                    if (cmd_go) begin
                        rp.req   <= 1'b1;
                        rp.we    <= dev_wr;
                        rp.addr  <= w_data[pwa_pkg::CMD_ADDR_LO +: pwa_pkg::REG_AW];
                        rp.wdata <= wdat_reg;
                        state    <= pwa_pkg::ST_WAIT;
                    end
                end
                pwa_pkg::ST_WAIT: begin
                    if (rp.ack) begin
                        rdat_reg <= rp.rdata;
                        state    <= pwa_pkg::ST_IDLE;
                    end
                end
                default: state <= pwa_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // init-complete gating: sdram mask and offset must be written first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_done     <= 1'b0;
            offs_done     <= 1'b0;
            bad_mask      <= 1'b0;
            init_complete <= 1'b0;
        end else begin
            if (state == pwa_pkg::ST_WAIT && rp.ack && rp.we) begin
                if (rp.addr == pwa_pkg::OFS_SDRAM_MASK) begin
                    mask_done <= 1'b1; // [RULE14]
                end
                if (rp.addr == pwa_pkg::OFS_SDRAM_OFFS) begin
                    offs_done <= 1'b1; // [RULE14]
                end
                if (rp.addr == pwa_pkg::OFS_CSR_MASK || rp.addr == pwa_pkg::OFS_SDRAM_MASK) begin
                    bad_mask <= !legal; // [RULE8] [RULE13]
                end
            end
            if (wr_fire && aw_addr == pwa_pkg::CTL_CONTROL) begin
                init_complete <= w_data[pwa_pkg::INIT_BIT] && mask_done && offs_done; // [RULE14]
            end
        end
    end
endmodule // pwa_ctl

// *** hdl/pwa_pkg.sv ***
// constants shared by the window register bank and its controller
// assumes one 100 MHz clock and a synchronous active-low reset
package pwa_pkg;
    // ==========================================================
    // device register map (byte offsets on the register port)
    localparam int          REG_AW          = 9;
    localparam logic [8:0]  OFS_UPPER_CH1   = 9'h094;
    localparam logic [8:0]  OFS_UPPER_CH2   = 9'h0B4;
    localparam logic [8:0]  OFS_CSR_MASK    = 9'h0F8;
    localparam logic [8:0]  OFS_CSR_OFFSET  = 9'h0FC;
    localparam logic [8:0]  OFS_SDRAM_MASK  = 9'h100;
    localparam logic [8:0]  OFS_SDRAM_OFFS  = 9'h104;
    localparam logic [8:0]  OFS_CSR_BAR     = 9'h010;
    localparam logic [8:0]  OFS_SDRAM_BAR   = 9'h018;
    // ==========================================================
    // field layout and reset values
    localparam int          NUM_CH          = 2;
    localparam int          FLD_LO          = 18;
    localparam int          FLD_HI          = 27;
    localparam int          DIS_BIT         = 31;
    localparam logic [31:0] FLD_BITS        = 32'h0FFC0000;
    localparam logic [31:0] SDRAM_MASK_RW   = 32'h8FFC0000;
    localparam logic [31:0] CSR_BAR_FIXED   = 32'hF003FF80;
    localparam logic [31:0] SDRAM_TOP_BITS  = 32'hF0000000;
    localparam logic [31:0] NO_WINDOW       = 32'h8FFC0000;
    localparam logic [31:0] RST_VAL         = 32'h00000000;
    localparam logic [31:0] ZERO32          = 32'h00000000;
    // ==========================================================
    // controller register map (AXI4-Lite byte addresses)
    localparam logic [7:0]  CTL_CMD         = 8'h00;
    localparam logic [7:0]  CTL_WDATA       = 8'h04;
    localparam logic [7:0]  CTL_RDATA       = 8'h08;
    localparam logic [7:0]  CTL_STATUS      = 8'h0C;
    localparam logic [7:0]  CTL_CONTROL     = 8'h10;
    localparam int          CMD_WE_BIT      = 0;
    localparam int          CMD_ADDR_LO     = 8;
    localparam int          INIT_BIT        = 1;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } pwa_state_e;
endpackage

// *** hdl/pwa_if.sv ***
// register port between the window bank and its local controller
// assumes both ends share aclk; ack answers every req next cycle
`timescale 1ns/10ps
interface pwa_if;
    logic        req;
    logic        we;
    logic [8:0]  addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;
    modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
    modport ctl (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// *** hdl/pwa_dev.sv ***
// window address register bank: dma upper addresses, csr and sdram
// window masks, offsets, base registers and address translation
// assumes descriptor, done and pci strobes are synchronous one-cycle pulses
`timescale 1ns/10ps
// Overview of operation
// RULE1: each channel keeps 32-bit upper address register
// RULE2: zero upper selects single cycles, else dual
// RULE3: load upper from first descriptor fourth dword
// RULE4: later descriptors keep or reload per control
// RULE5: reset and channel done clear upper register
// RULE6: upper register never increments during transfer
// RULE7: csr mask bits force csr base bits zero
// RULE8: csr mask takes only listed legal encodings (code stores any field value and flags illegal ones in bad_mask)
// RULE9: csr offset bit used where mask clear
// RULE10: sdram mask bits force sdram base bits zero
// RULE11: disable bit zeroes sdram base bits 31:28
// RULE12: no window value 8FFC0000h zeroes whole base
// RULE13: sdram mask takes only listed legal encodings (code stores the field and disable bit of any value and flags illegal ones in bad_mask)
// RULE14: mask and offset written before init complete
// RULE15: sdram offset bit used where mask clear
// RULE16: reserved bits read zero, masked bits pass
module pwa_dev (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    pwa_if.dev               rp,
    input  wire logic [1:0]  desc_fetch,
    input  wire logic [1:0]  desc_reload,
    input  wire logic [31:0] desc_dw4_ch1,
    input  wire logic [31:0] desc_dw4_ch2,
    input  wire logic [1:0]  chan_done,
    input  wire logic        csr_sel,
    input  wire logic        sdram_sel,
    input  wire logic [31:0] pci_addr,
    output logic [31:0]      upper_ch1,
    output logic [31:0]      upper_ch2,
    output logic [1:0]       dual_cycle,
    output logic [31:0]      csr_local_addr,
    output logic             csr_local_valid,
    output logic [31:0]      sdram_local_addr,
    output logic             sdram_local_valid
);
    // ==========================================================
    // storage
    logic [31:0] upper [pwa_pkg::NUM_CH];
    logic [31:0] csr_mask;
    logic [31:0] csr_offs;
    logic [31:0] sdram_mask;
    logic [31:0] sdram_offs;
    logic [31:0] csr_bar;
    logic [31:0] sdram_bar;
    logic [31:0] csr_bar_rw;
    logic [31:0] sdram_bar_rw;
    logic [31:0] desc_dw4 [pwa_pkg::NUM_CH];
    logic [8:0]  ch_ofs [pwa_pkg::NUM_CH];
    logic        wr;
    logic [31:0] next_rdata;

    assign wr          = rp.req && rp.we;
    assign desc_dw4[0] = desc_dw4_ch1;
    assign desc_dw4[1] = desc_dw4_ch2;
    assign ch_ofs[0]   = pwa_pkg::OFS_UPPER_CH1;
    assign ch_ofs[1]   = pwa_pkg::OFS_UPPER_CH2;

    // ==========================================================
    // writable bits of the two base registers
    // recomputed from the live masks, so a later mask hides old bits too
    always_comb begin
        csr_bar_rw   = pwa_pkg::CSR_BAR_FIXED | (~csr_mask & pwa_pkg::FLD_BITS); // [RULE7]
        sdram_bar_rw = ~sdram_mask & pwa_pkg::FLD_BITS; // [RULE10]
        if (!sdram_mask[pwa_pkg::DIS_BIT]) begin
            sdram_bar_rw = sdram_bar_rw | pwa_pkg::SDRAM_TOP_BITS; // [RULE11]
        end
    end

    // ==========================================================
    // dma upper address registers
    // done clear beats a descriptor load in the same cycle; the chain is over
    always_ff @(posedge aclk) begin
        for (int ch = 0; ch < pwa_pkg::NUM_CH; ch++) begin
            if (!aresetn) begin
                upper[ch] <= pwa_pkg::RST_VAL; // [RULE5]
            end else if (chan_done[ch]) begin
                upper[ch] <= pwa_pkg::RST_VAL; // [RULE5]
            end else if (desc_fetch[ch] && desc_reload[ch]) begin
                upper[ch] <= desc_dw4[ch]; // [RULE3] [RULE4]
            end else if (wr && rp.addr == ch_ofs[ch]) begin
                upper[ch] <= rp.wdata; // [RULE1] [RULE3]
            end
            // no increment path exists: 4GB crossings need a new descriptor [RULE6]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_ch1  <= pwa_pkg::RST_VAL;
            upper_ch2  <= pwa_pkg::RST_VAL;
            dual_cycle <= 2'h0;
        end else begin
            upper_ch1     <= upper[0]; // [RULE1]
            upper_ch2     <= upper[1]; // [RULE1]
            dual_cycle[0] <= (upper[0] != pwa_pkg::ZERO32); // [RULE2]
            dual_cycle[1] <= (upper[1] != pwa_pkg::ZERO32); // [RULE2]
        end
    end

    // ==========================================================
    // window masks and offsets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_mask   <= pwa_pkg::RST_VAL;
            csr_offs   <= pwa_pkg::RST_VAL;
            sdram_mask <= pwa_pkg::RST_VAL;
            sdram_offs <= pwa_pkg::RST_VAL;
        end else if (wr) begin
            case (rp.addr)
                pwa_pkg::OFS_CSR_MASK:   csr_mask   <= rp.wdata & pwa_pkg::FLD_BITS; // [RULE16]
                pwa_pkg::OFS_CSR_OFFSET: csr_offs   <= rp.wdata & pwa_pkg::FLD_BITS; // [RULE16]
                pwa_pkg::OFS_SDRAM_MASK: sdram_mask <= rp.wdata & pwa_pkg::SDRAM_MASK_RW;
                pwa_pkg::OFS_SDRAM_OFFS: sdram_offs <= rp.wdata & pwa_pkg::FLD_BITS; // [RULE16]
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // base registers, written by configuration software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_bar   <= pwa_pkg::RST_VAL;
            sdram_bar <= pwa_pkg::RST_VAL;
        end else if (wr && rp.addr == pwa_pkg::OFS_CSR_BAR) begin
            csr_bar <= rp.wdata & csr_bar_rw; // [RULE7]
        end else if (wr && rp.addr == pwa_pkg::OFS_SDRAM_BAR) begin
            sdram_bar <= rp.wdata & sdram_bar_rw; // [RULE10] [RULE11]
        end
    end

    // ==========================================================
    // register read path; unmapped offsets read zero
    always_comb begin
        case (rp.addr)
            pwa_pkg::OFS_UPPER_CH1:  next_rdata = upper[0];
            pwa_pkg::OFS_UPPER_CH2:  next_rdata = upper[1];
            pwa_pkg::OFS_CSR_MASK:   next_rdata = csr_mask;
            pwa_pkg::OFS_CSR_OFFSET: next_rdata = csr_offs;
            pwa_pkg::OFS_SDRAM_MASK: next_rdata = sdram_mask;
            pwa_pkg::OFS_SDRAM_OFFS: next_rdata = sdram_offs;
            pwa_pkg::OFS_CSR_BAR:    next_rdata = csr_bar & csr_bar_rw; // [RULE7]
            pwa_pkg::OFS_SDRAM_BAR:  next_rdata = sdram_bar & sdram_bar_rw; // [RULE10] [RULE12]
            default:                 next_rdata = pwa_pkg::ZERO32;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rp.ack   <= 1'b0;
            rp.rdata <= pwa_pkg::ZERO32;
        end else begin
            rp.ack <= rp.req;
            if (rp.req) begin
                rp.rdata <= next_rdata;
            end
        end
    end

    // ==========================================================
    // pci-to-local address translation, one cycle of latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_local_addr    <= pwa_pkg::ZERO32;
            csr_local_valid   <= 1'b0;
            sdram_local_addr  <= pwa_pkg::ZERO32;
            sdram_local_valid <= 1'b0;
        end else begin
            csr_local_valid   <= csr_sel;
            sdram_local_valid <= sdram_sel;
            if (csr_sel) begin
                csr_local_addr <= (pci_addr & (csr_mask | ~pwa_pkg::FLD_BITS))
                                | (csr_offs & ~csr_mask); // [RULE9] [RULE16]
            end
            if (sdram_sel) begin
                sdram_local_addr <= (pci_addr & (sdram_mask | ~pwa_pkg::FLD_BITS))
                                  | (sdram_offs & ~sdram_mask & pwa_pkg::FLD_BITS); // [RULE15]
            end
        end
    end
endmodule // pwa_dev

// *** bench/pwa_asserts.sv ***
// checker for the window bank: register port and dma side signals
// assumes instantiation beside the interface, one clock domain
`timescale 1ns/10ps
module pwa_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        req,
    input wire logic        ack,
    input wire logic [1:0]  desc_fetch,
    input wire logic [1:0]  desc_reload,
    input wire logic [31:0] desc_dw4_ch1,
    input wire logic [31:0] desc_dw4_ch2,
    input wire logic [1:0]  chan_done,
    input wire logic        csr_sel,
    input wire logic        sdram_sel,
    input wire logic [31:0] upper_ch1,
    input wire logic [31:0] upper_ch2,
    input wire logic [1:0]  dual_cycle,
    input wire logic        csr_local_valid,
    input wire logic        sdram_local_valid
);
    // ==========================================================
    // properties: upper outputs lag the internal register by one cycle
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ack; req |=> ack ##1 !ack; endproperty
    property p_load1; desc_fetch[0] && desc_reload[0] && !chan_done[0]
        |-> ##2 upper_ch1 == $past(desc_dw4_ch1, 2); endproperty
    property p_load2; desc_fetch[1] && desc_reload[1] && !chan_done[1]
        |-> ##2 upper_ch2 == $past(desc_dw4_ch2, 2); endproperty
    property p_keep1; !req && !(desc_fetch[0] && desc_reload[0]) && !chan_done[0]
        |-> ##2 $stable(upper_ch1); endproperty
    property p_done1; chan_done[0] |-> ##2 upper_ch1 == 32'h0; endproperty
    property p_done2; chan_done[1] |-> ##2 upper_ch2 == 32'h0; endproperty
    property p_dual; dual_cycle == {upper_ch2 != 32'h0, upper_ch1 != 32'h0}; endproperty
    property p_csr_v; csr_sel |=> csr_local_valid; endproperty
    property p_sdram_v; sdram_sel |=> sdram_local_valid; endproperty
    a_ack: assert property (p_ack) else $error("bank ack missing");
    a_load1: assert property (p_load1) else $error("ch1 load wrong");
    a_load2: assert property (p_load2) else $error("ch2 load wrong");
    a_keep1: assert property (p_keep1) else $error("ch1 upper moved");
    a_done1: assert property (p_done1) else $error("ch1 not cleared");
    a_done2: assert property (p_done2) else $error("ch2 not cleared");
    a_dual: assert property (p_dual) else $error("dual select wrong");
    a_csr_v: assert property (p_csr_v) else $error("csr valid missing");
    a_sdram_v: assert property (p_sdram_v) else $error("sdram valid missing");
    c_load: cover property (desc_fetch[0] && desc_reload[0]);
    c_done: cover property (chan_done[1]);
    c_sel: cover property (csr_sel ##1 csr_local_valid);
endmodule // pwa_asserts

// *** bench/testbench.sv ***
// self-checking bench: controller and bank joined by the register port
// assumes AXI4-Lite timing and a one-cycle bank answer
`timescale 1ns/10ps
module testbench;
    // ==========================================================
    // signals
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, desc_dw4_ch1, desc_dw4_ch2, pci_addr;
    logic        awready, wready, bvalid, arready, rvalid, init_complete;
    logic [1:0]  bresp, rresp, desc_fetch, desc_reload, chan_done, dual_cycle;
    logic        csr_sel, sdram_sel, csr_local_valid, sdram_local_valid;
    logic [31:0] upper_ch1, upper_ch2, csr_local_addr, sdram_local_addr;
    int          errors = 0, total_checks = 0;
    pwa_if bus_if ();
    pwa_dev i_pwa_dev (.rp(bus_if.dev), .*);
    pwa_ctl i_pwa_ctl (.rp(bus_if.ctl), .wstrb(4'hF), .*);
    pwa_asserts i_pwa_asserts (.req(bus_if.req), .ack(bus_if.ack), .*);
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic bound(input int n);
        if (n >= 50) begin
            errors++;
            $display("MISMATCH at %0t: handshake timeout", $time);
            end_sim();
        end
    endtask
    // master waits for the answer, never a fixed count
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        awaddr  <= a;
        wdata   <= d;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid && n < 50);
        bound(n);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        arvalid <= 1'h1;
        rready  <= 1'h1;
        araddr  <= a;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (!rvalid && n < 50);
        bound(n);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    task automatic bank_op(input logic [8:0] o, input logic we, input logic [31:0] d,
                           output logic [31:0] q);
        logic [1:0]  r;
        logic [31:0] s;
        int          n = 0;
        axi_wr(pwa_pkg::CTL_WDATA, d, r);
        axi_wr(pwa_pkg::CTL_CMD, {15'h0, o, 7'h0, we}, r);
        do begin
            axi_rd(pwa_pkg::CTL_STATUS, s, r);
            n++;
        end while (s[0] && n < 50);
        bound(n);
        axi_rd(pwa_pkg::CTL_RDATA, q, r);
    endtask
    task automatic bank_chk(input logic [8:0] o, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bank_op(o, 1'h0, 32'h0, q);
        check(q, exp, what);
    endtask
    // one dma pulse; outputs are two flops behind it
    task automatic dma_pulse(input logic [1:0] f, rl, dn, input logic [31:0] d1, d2);
        @(posedge aclk);
        desc_fetch   <= f;
        desc_reload  <= rl;
        chan_done    <= dn;
        desc_dw4_ch1 <= d1;
        desc_dw4_ch2 <= d2;
        @(posedge aclk);
        {desc_fetch, chan_done} <= 4'h0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic pci_hit(input logic c, input logic [31:0] a);
        @(posedge aclk);
        {csr_sel, sdram_sel} <= {c, !c};
        pci_addr  <= a;
        @(posedge aclk);
        {csr_sel, sdram_sel} <= 2'h0;
        @(posedge aclk);
    endtask
    function automatic logic [31:0] xlate(logic [31:0] a, m, o);
        return (a & ~(pwa_pkg::FLD_BITS & ~m)) | (o & pwa_pkg::FLD_BITS & ~m);
    endfunction
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [8:0]  ofs [6] = '{pwa_pkg::OFS_UPPER_CH1, pwa_pkg::OFS_UPPER_CH2,
            pwa_pkg::OFS_CSR_MASK, pwa_pkg::OFS_CSR_OFFSET, pwa_pkg::OFS_SDRAM_MASK,
            pwa_pkg::OFS_SDRAM_OFFS};
        logic [31:0] q;
        logic [1:0]  r;
        foreach (ofs[i]) bank_chk(ofs[i], pwa_pkg::RST_VAL, "reset value");
        axi_rd(8'h40, q, r);
        check({30'h0, r}, {30'h0, pwa_pkg::RESP_SLVERR}, "unmapped read");
        axi_wr(8'h40, 32'h1, r);
        check({30'h0, r}, {30'h0, pwa_pkg::RESP_SLVERR}, "unmapped write");
    endtask
    task automatic t_upper();
        logic [31:0] q;
        bank_op(pwa_pkg::OFS_UPPER_CH1, 1'h1, 32'h89ABCDEF, q);
        bank_chk(pwa_pkg::OFS_UPPER_CH1, 32'h89ABCDEF, "ch1 upper");
        check({30'h0, dual_cycle}, 32'h1, "dual ch1 only");
        dma_pulse(2'h3, 2'h1, 2'h0, 32'h0, 32'h12345678);
        check(upper_ch1, 32'h0, "ch1 loaded zero");
        check(upper_ch2, 32'h0, "ch2 kept");
        check({30'h0, dual_cycle}, 32'h0, "single cycles");
        dma_pulse(2'h3, 2'h2, 2'h0, 32'hFFFFFFFF, 32'h00000001);
        check(upper_ch1, 32'h0, "ch1 not reloaded");
        check(upper_ch2, 32'h00000001, "ch2 reloaded");
        dma_pulse(2'h3, 2'h3, 2'h3, 32'h00000003, 32'h00000005);
        check(upper_ch1, 32'h0, "ch1 done wins");
        check(upper_ch2, 32'h0, "done wins over load");
    endtask
    task automatic t_csr();
        logic [31:0] q;
        logic [1:0]  r;
        logic [31:0] m = 32'h003C0000; // legal 4MB window
        bank_op(pwa_pkg::OFS_CSR_MASK, 1'h1, m | 32'hF003FFFF, q);
        axi_rd(pwa_pkg::CTL_STATUS, q, r);
        check(q, 32'h2, "reserved bits flag mask");
        bank_chk(pwa_pkg::OFS_CSR_MASK, m, "csr mask reserved");
        bank_op(pwa_pkg::OFS_CSR_OFFSET, 1'h1, 32'hFFFFFFFF, q);
        bank_chk(pwa_pkg::OFS_CSR_OFFSET, pwa_pkg::FLD_BITS, "csr offset");
        bank_op(pwa_pkg::OFS_CSR_BAR, 1'h1, 32'hFFFFFFFF, q);
        bank_chk(pwa_pkg::OFS_CSR_BAR, pwa_pkg::CSR_BAR_FIXED | (pwa_pkg::FLD_BITS & ~m),
                 "csr base");
        pci_hit(1'h1, 32'h12345678);
        check(csr_local_addr, xlate(32'h12345678, m, pwa_pkg::FLD_BITS), "csr xlate");
    endtask
    task automatic t_sdram();
        logic [31:0] q;
        logic [1:0]  r;
        logic [31:0] m = 32'h001C0000; // legal 2MB window
        axi_wr(pwa_pkg::CTL_CONTROL, 32'h2, r);
        check({31'h0, init_complete}, 32'h0, "init too early");
        bank_op(pwa_pkg::OFS_SDRAM_MASK, 1'h1, m, q);
        bank_op(pwa_pkg::OFS_SDRAM_OFFS, 1'h1, 32'hF5500001, q);
        bank_chk(pwa_pkg::OFS_SDRAM_OFFS, 32'h05500000, "sdram offset");
        bank_op(pwa_pkg::OFS_SDRAM_BAR, 1'h1, 32'hFFFFFFFF, q);
        bank_chk(pwa_pkg::OFS_SDRAM_BAR, pwa_pkg::SDRAM_TOP_BITS | (pwa_pkg::FLD_BITS & ~m),
                 "sdram base");
        pci_hit(1'h0, 32'hABCDEF01);
        check(sdram_local_addr, xlate(32'hABCDEF01, m, 32'h05500000), "sdram xlate");
        bank_op(pwa_pkg::OFS_SDRAM_MASK, 1'h1, pwa_pkg::NO_WINDOW, q);
        bank_op(pwa_pkg::OFS_SDRAM_BAR, 1'h1, 32'hFFFFFFFF, q);
        bank_chk(pwa_pkg::OFS_SDRAM_BAR, 32'h0, "no window base");
        axi_wr(pwa_pkg::CTL_CONTROL, 32'h2, r);
        check({31'h0, init_complete}, 32'h1, "init complete");
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, csr_sel, sdram_sel} = 8'h0;
        {awaddr, araddr, wdata, pci_addr, desc_dw4_ch1, desc_dw4_ch2} = 144'h0;
        {desc_fetch, desc_reload, chan_done} = 6'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_upper();
        t_csr();
        t_sdram();
        end_sim();
    end
endmodule // testbench
